// ### rtl/lom_pkg.sv
// Constants, register map and carrier types of the link OAM event monitor.
package lom_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         TICK_MS   = 100;
  localparam int         CLK_KHZ   = 125000;
  localparam int         TICK_CYC  = TICK_MS * CLK_KHZ;
  localparam logic [3:0] SEC_LAST  = 4'h9;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] FE_WIN_RST = 16'h000A;
  localparam logic [15:0] FE_WIN_MIN = 16'h000A;
  localparam logic [15:0] FE_WIN_MAX = 16'h0258;
  localparam logic [31:0] FE_THR_RST = 32'h0000_0001;
  localparam logic [31:0] FP_WIN_RST = 32'h0001_0000;
  localparam logic [31:0] FP_THR_RST = 32'h0000_0001;
  localparam logic [63:0] SP_WIN_RST = 64'h0000_0000_05F5_E100;
  localparam logic [63:0] SP_THR_RST = 64'h0000_0000_0000_0001;
  localparam logic [15:0] ES_WIN_RST = 16'h0258;
  localparam logic [15:0] ES_WIN_MIN = 16'h0001;
  localparam logic [15:0] ES_THR_RST = 16'h0001;
  localparam int          CTRL_CLR   = 0;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SEQ    = 8'h04;
  localparam logic [7:0] A_FE_WIN = 8'h08;
  localparam logic [7:0] A_FE_THR = 8'h0C;
  localparam logic [7:0] A_FE_CNT = 8'h10;
  localparam logic [7:0] A_FE_TL  = 8'h14;
  localparam logic [7:0] A_FE_TH  = 8'h18;
  localparam logic [7:0] A_FE_EV  = 8'h1C;
  localparam logic [7:0] A_FE_TS  = 8'h20;
  localparam logic [7:0] A_FP_WIN = 8'h24;
  localparam logic [7:0] A_FP_THR = 8'h28;
  localparam logic [7:0] A_FP_CNT = 8'h2C;
  localparam logic [7:0] A_FP_TL  = 8'h30;
  localparam logic [7:0] A_FP_TH  = 8'h34;
  localparam logic [7:0] A_FP_EV  = 8'h38;
  localparam logic [7:0] A_FP_TS  = 8'h3C;
  localparam logic [7:0] A_SP_WL  = 8'h40;
  localparam logic [7:0] A_SP_WH  = 8'h44;
  localparam logic [7:0] A_SP_RL  = 8'h48;
  localparam logic [7:0] A_SP_RH  = 8'h4C;
  localparam logic [7:0] A_SP_CL  = 8'h50;
  localparam logic [7:0] A_SP_CH  = 8'h54;
  localparam logic [7:0] A_SP_TL  = 8'h58;
  localparam logic [7:0] A_SP_TH  = 8'h5C;
  localparam logic [7:0] A_SP_EV  = 8'h60;
  localparam logic [7:0] A_SP_TS  = 8'h64;
  localparam logic [7:0] A_ES_WIN = 8'h68;
  localparam logic [7:0] A_ES_THR = 8'h6C;
  localparam logic [7:0] A_ES_CNT = 8'h70;
  localparam logic [7:0] A_ES_TOT = 8'h74;
  localparam logic [7:0] A_ES_EV  = 8'h78;
  localparam logic [7:0] A_ES_TS  = 8'h7C;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frame_rx;
    logic frame_err;
    logic sym_rx;
    logic sym_err;
  } lom_err_s;

  typedef struct packed {
    logic seconds;
    logic symbol;
    logic period;
    logic frame;
  } lom_evt_s;

endpackage : lom_pkg

// ### rtl/lom_monitor.sv
// Link OAM event monitor with windows, thresholds, totals and APB access.
`timescale 1ns/1ns
// What this block does
// - Count remote link events in a 16-bit sequence value.
// - Stamp each event type with a 16-bit time in 100 ms units.
// - Frame window is 16 bits of 100 ms, default 1 s, 1 s to 60 s.
// - Frame event when window errors reach the 32-bit threshold, default one.
// - Count errored frames of the current frame window in 32 bits.
// - Keep a 64-bit total of errored frames since the last clear.
// - Count frame events in 32 bits since the last clear.
// - Period window is a 32-bit count of received frames.
// - Period event when period errors reach the 32-bit threshold.
// - Keep 32-bit period error count and 64-bit period error total.
// - Count period events in 32 bits since the last clear.
// - Symbol window is a 64-bit count of received symbols.
// - Symbol event when window symbol errors reach the 64-bit threshold.
// - Keep 64-bit symbol error count and 64-bit symbol error total.
// - Count symbol events in 32 bits since the last clear.
// - Seconds window and its timestamp are 16 bits of 100 ms.
// - Seconds event when 16-bit errored seconds reach 16-bit threshold.
// - Keep a 32-bit total of errored seconds since the last clear.
// - Count seconds events in 32 bits since the last clear.
module lom_monitor
  import lom_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire lom_err_s    err_in,
  input  wire logic        oam_reset,
  input  wire logic        remote_event,
  output lom_evt_s         evt
);

  if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least one");

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] tick_age;
  logic [15:0] ts_now, seq_reg;
  logic [15:0] fe_win, fe_age, fe_ts, fp_ts, sp_ts, es_ts;
  logic [31:0] fe_thr, fe_cnt, fe_ev, fp_ev, sp_ev, es_ev;
  logic [63:0] fe_tot, fp_tot, sp_tot;
  logic [31:0] fp_win, fp_thr, fp_age, fp_cnt, es_tot;
  logic [63:0] sp_win, sp_thr, sp_age, sp_cnt;
  logic [15:0] es_win, es_thr, es_age, es_cnt;
  logic [3:0]  sec_age;
  logic        sec_bad;
  logic        tick, clr, acc, wr, rd_ok;
  logic        fe_exp, fp_exp, sp_exp, es_exp, sec_end;
  logic        fe_hit, fp_hit, sp_hit, es_hit;
  logic [31:0] fe_close, fp_close;
  logic [63:0] sp_close;
  logic [15:0] es_close, fe_wv;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Window control
  // ----------------------------------------------------------------
  // Errors landing in the expiry cycle are folded into the closing value.
  always_comb
  begin
    tick     = (tick_age == 32'(TICK_CYCLES - 1));
    acc      = psel & penable & pready;
    wr       = acc & pwrite & ~pslverr;
    clr      = oam_reset | (wr & (paddr == A_CTRL) & pwdata[CTRL_CLR]);
    fe_exp   = tick & ((fe_age + 16'h0001) >= fe_win);
    fp_exp   = err_in.frame_rx & ((fp_age + 32'h0000_0001) >= fp_win);
    sp_exp   = err_in.sym_rx & ((sp_age + 64'h1) >= sp_win);
    sec_end  = tick & (sec_age == SEC_LAST);
    es_exp   = tick & ((es_age + 16'h0001) >= es_win);
    fe_close = fe_cnt + {31'h0, err_in.frame_err};
    fp_close = fp_cnt + {31'h0, err_in.frame_err};
    sp_close = sp_cnt + {63'h0, err_in.sym_err};
    es_close = es_cnt + {15'h0, sec_end & (sec_bad | err_in.frame_err)};
    fe_hit   = fe_close >= fe_thr;
    fp_hit   = fp_close >= fp_thr;
    sp_hit   = sp_close >= sp_thr;
    es_hit   = es_close >= es_thr;
    // Clamp keeps a software write inside the legal frame window range.
    if (pwdata[15:0] < FE_WIN_MIN)
      fe_wv = FE_WIN_MIN;
    else if (pwdata[15:0] > FE_WIN_MAX)
      fe_wv = FE_WIN_MAX;
    else
      fe_wv = pwdata[15:0];
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // A 100 ms tick drives the timestamp and the time based windows.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_age <= 32'h0000_0000;
      ts_now   <= 16'h0000;
    end
    else if (tick)
    begin
      tick_age <= 32'h0000_0000;
      ts_now   <= ts_now + 16'h0001;
    end
    else
      tick_age <= tick_age + 32'h0000_0001;
  end

  // Remote sequence value wraps, as a two-octet field does on the wire.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq_reg <= 16'h0000;
    else if (clr)
      seq_reg <= 16'h0000;
    else if (remote_event)
      seq_reg <= seq_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fe_win <= FE_WIN_RST;
      fe_thr <= FE_THR_RST;
      fp_win <= FP_WIN_RST;
      fp_thr <= FP_THR_RST;
      sp_win <= SP_WIN_RST;
      sp_thr <= SP_THR_RST;
      es_win <= ES_WIN_RST;
      es_thr <= ES_THR_RST;
    end
    else if (wr)
    begin
      unique case (paddr)
        A_FE_WIN: fe_win <= fe_wv;
        A_FE_THR: fe_thr <= pwdata;
        A_FP_WIN: fp_win <= pwdata;
        A_FP_THR: fp_thr <= pwdata;
        A_SP_WL:  sp_win[31:0] <= pwdata;
        A_SP_WH:  sp_win[63:32] <= pwdata;
        A_SP_RL:  sp_thr[31:0] <= pwdata;
        A_SP_RH:  sp_thr[63:32] <= pwdata;
        A_ES_WIN: es_win <= (pwdata[15:0] < ES_WIN_MIN) ? ES_WIN_MIN
                                                         : pwdata[15:0];
        A_ES_THR: es_thr <= pwdata[15:0];
        default:  fe_thr <= fe_thr;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Errored frame window
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fe_age <= 16'h0000;
      fe_cnt <= 32'h0000_0000;
      fe_tot <= 64'h0;
      fe_ev  <= 32'h0000_0000;
      fe_ts  <= 16'h0000;
    end
    else if (clr)
    begin
      fe_age <= 16'h0000;
      fe_cnt <= 32'h0000_0000;
      fe_tot <= 64'h0;
      fe_ev  <= 32'h0000_0000;
    end
    else if (fe_exp)
    begin
      fe_age <= 16'h0000;
      fe_cnt <= 32'h0000_0000;
      fe_tot <= fe_tot + {32'h0, fe_close};
      if (fe_hit)
      begin
        fe_ev <= fe_ev + 32'h0000_0001;
        fe_ts <= ts_now;
      end
    end
    else
    begin
      fe_age <= fe_age + {15'h0, tick};
      fe_cnt <= fe_close;
    end
  end

  // ----------------------------------------------------------------
  // Errored frame period window
  // ----------------------------------------------------------------
  // The period is measured in received frames, so it stalls with no traffic.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fp_age <= 32'h0000_0000;
      fp_cnt <= 32'h0000_0000;
      fp_tot <= 64'h0;
      fp_ev  <= 32'h0000_0000;
      fp_ts  <= 16'h0000;
    end
    else if (clr)
    begin
      fp_age <= 32'h0000_0000;
      fp_cnt <= 32'h0000_0000;
      fp_tot <= 64'h0;
      fp_ev  <= 32'h0000_0000;
    end
    else if (fp_exp)
    begin
      fp_age <= 32'h0000_0000;
      fp_cnt <= 32'h0000_0000;
      fp_tot <= fp_tot + {32'h0, fp_close};
      if (fp_hit)
      begin
        fp_ev <= fp_ev + 32'h0000_0001;
        fp_ts <= ts_now;
      end
    end
    else
    begin
      fp_age <= fp_age + {31'h0, err_in.frame_rx};
      fp_cnt <= fp_close;
    end
  end

  // ----------------------------------------------------------------
  // Errored symbol window
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_age <= 64'h0;
      sp_cnt <= 64'h0;
      sp_tot <= 64'h0;
      sp_ev  <= 32'h0000_0000;
      sp_ts  <= 16'h0000;
    end
    else if (clr)
    begin
      sp_age <= 64'h0;
      sp_cnt <= 64'h0;
      sp_tot <= 64'h0;
      sp_ev  <= 32'h0000_0000;
    end
    else if (sp_exp)
    begin
      sp_age <= 64'h0;
      sp_cnt <= 64'h0;
      sp_tot <= sp_tot + sp_close;
      if (sp_hit)
      begin
        sp_ev <= sp_ev + 32'h0000_0001;
        sp_ts <= ts_now;
      end
    end
    else
    begin
      sp_age <= sp_age + {63'h0, err_in.sym_rx};
      sp_cnt <= sp_close;
    end
  end

  // ----------------------------------------------------------------
  // Errored frame seconds window
  // ----------------------------------------------------------------
  // A second is errored when any errored frame arrived during it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_age <= 4'h0;
      sec_bad <= 1'b0;
    end
    else if (clr || sec_end)
    begin
      sec_age <= 4'h0;
      sec_bad <= 1'b0;
    end
    else
    begin
      sec_age <= sec_age + {3'h0, tick};
      sec_bad <= sec_bad | err_in.frame_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      es_age <= 16'h0000;
      es_cnt <= 16'h0000;
      es_tot <= 32'h0000_0000;
      es_ev  <= 32'h0000_0000;
      es_ts  <= 16'h0000;
    end
    else if (clr)
    begin
      es_age <= 16'h0000;
      es_cnt <= 16'h0000;
      es_tot <= 32'h0000_0000;
      es_ev  <= 32'h0000_0000;
    end
    else if (es_exp)
    begin
      es_age <= 16'h0000;
      es_cnt <= 16'h0000;
      es_tot <= es_tot + {16'h0, es_close};
      if (es_hit)
      begin
        es_ev <= es_ev + 32'h0000_0001;
        es_ts <= ts_now;
      end
    end
    else
    begin
      es_age <= es_age + {15'h0, tick};
      es_cnt <= es_close;
    end
  end

  // Event strobes last one cycle; a clear in the same cycle suppresses them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt <= '0;
    else
    begin
      evt.frame   <= ~clr & fe_exp & fe_hit;
      evt.period  <= ~clr & fp_exp & fp_hit;
      evt.symbol  <= ~clr & sp_exp & sp_hit;
      evt.seconds <= ~clr & es_exp & es_hit;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data is latched in setup, so the answer costs no wait state.
  always_comb
  begin
    rd_ok = 1'b1;
    unique case (paddr)
      A_CTRL:   rd_word = 32'h0000_0000;
      A_SEQ:    rd_word = {16'h0, seq_reg};
      A_FE_WIN: rd_word = {16'h0, fe_win};
      A_FE_THR: rd_word = fe_thr;
      A_FE_CNT: rd_word = fe_cnt;
      A_FE_TL:  rd_word = fe_tot[31:0];
      A_FE_TH:  rd_word = fe_tot[63:32];
      A_FE_EV:  rd_word = fe_ev;
      A_FE_TS:  rd_word = {16'h0, fe_ts};
      A_FP_WIN: rd_word = fp_win;
      A_FP_THR: rd_word = fp_thr;
      A_FP_CNT: rd_word = fp_cnt;
      A_FP_TL:  rd_word = fp_tot[31:0];
      A_FP_TH:  rd_word = fp_tot[63:32];
      A_FP_EV:  rd_word = fp_ev;
      A_FP_TS:  rd_word = {16'h0, fp_ts};
      A_SP_WL:  rd_word = sp_win[31:0];
      A_SP_WH:  rd_word = sp_win[63:32];
      A_SP_RL:  rd_word = sp_thr[31:0];
      A_SP_RH:  rd_word = sp_thr[63:32];
      A_SP_CL:  rd_word = sp_cnt[31:0];
      A_SP_CH:  rd_word = sp_cnt[63:32];
      A_SP_TL:  rd_word = sp_tot[31:0];
      A_SP_TH:  rd_word = sp_tot[63:32];
      A_SP_EV:  rd_word = sp_ev;
      A_SP_TS:  rd_word = {16'h0, sp_ts};
      A_ES_WIN: rd_word = {16'h0, es_win};
      A_ES_THR: rd_word = {16'h0, es_thr};
      A_ES_CNT: rd_word = {16'h0, es_cnt};
      A_ES_TOT: rd_word = es_tot;
      A_ES_EV:  rd_word = es_ev;
      A_ES_TS:  rd_word = {16'h0, es_ts};
      default:
      begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      if (psel && !penable)
        prdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_seq;
    remote_event && !clr |=> seq_reg == $past(seq_reg) + 16'h0001;
  endproperty
  a_seq: assert property (p_seq) else $error("sequence not counted");

  property p_fe_win;
    fe_win >= FE_WIN_MIN && fe_win <= FE_WIN_MAX;
  endproperty
  a_fe_win: assert property (p_fe_win) else $error("frame window out");

  // The stamp is only checked on a real event; a missing pulse still fails.
  property p_fe_evt;
    fe_exp && !clr |=> evt.frame == $past(fe_hit)
                       && (!evt.frame || fe_ts == $past(ts_now));
  endproperty
  a_fe_evt: assert property (p_fe_evt) else $error("frame event wrong");

  property p_fe_tot;
    fe_exp && !clr |=> fe_tot == $past(fe_tot) + {32'h0, $past(fe_close)}
                       && fe_cnt == 32'h0000_0000;
  endproperty
  a_fe_tot: assert property (p_fe_tot) else $error("frame total wrong");

  property p_fe_ev;
    evt.frame |-> fe_ev == $past(fe_ev) + 32'h0000_0001;
  endproperty
  a_fe_ev: assert property (p_fe_ev) else $error("frame events wrong");

  // A one-frame period may close again at once, so only the next cycle counts.
  property p_fp_evt;
    fp_exp && !clr && fp_close < fp_thr |=> !evt.period
                                            && fp_ev == $past(fp_ev);
  endproperty
  a_fp_evt: assert property (p_fp_evt) else $error("period event wrong");

  property p_sp_evt;
    sp_exp && !clr && sp_hit |=> evt.symbol && sp_cnt == 64'h0;
  endproperty
  a_sp_evt: assert property (p_sp_evt) else $error("symbol event wrong");

  property p_es_evt;
    es_exp && !clr |=> evt.seconds == $past(es_hit);
  endproperty
  a_es_evt: assert property (p_es_evt) else $error("seconds event wrong");

  property p_clr;
    clr |=> fe_tot == 64'h0 && sp_tot == 64'h0 && es_ev == 32'h0000_0000
            && fp_cnt == 32'h0000_0000 && seq_reg == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("clear incomplete");

endmodule : lom_monitor

// ### bench/lom_peer.sv
// Remote peer model that drives error indications and remote events.
`timescale 1ns/1ns
module lom_peer
  import lom_pkg::*;
(
  input  wire logic pclk,
  output lom_err_s  err_in,
  output logic      remote_event
);
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Lines idle low from time zero so no stray count is taken.
  initial
  begin
    err_in = '0;
    remote_event = 1'b0;
  end

  // Frames and symbols arrive one per cycle, errored ones first.
  task automatic burst(input int nf, input int fe, input int ns,
                       input int se);
    for (int i = 0; i < nf || i < ns; i++)
    begin
      @(posedge pclk);
      err_in <= '{i < nf, i < fe, i < ns, i < se};
    end
    @(posedge pclk);
    err_in <= '0;
  endtask : burst

  // Each reported event is its own pulse with a gap, never merged.
  task automatic events(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      remote_event <= 1'b1;
      @(posedge pclk);
      remote_event <= 1'b0;
    end
  endtask : events
endmodule : lom_peer

// ### bench/lom_monitor_test.sv
// Self-checking testbench of the link OAM event monitor.
`timescale 1ns/1ns
module lom_monitor_test
  import lom_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        oam_reset;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  lom_err_s    err_in;
  logic        remote_event;
  lom_evt_s    evt;
  logic [31:0] rdv;
  logic        errv;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seen[4] = '{default: 0};
  time         t0;
  time         t_fe;

  // ----------------------------------------------------------------
  // Clock, design and peer
  // ----------------------------------------------------------------
  // A tick of four cycles keeps one second at forty cycles.
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  lom_monitor #(.TICK_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .err_in(err_in),
    .oam_reset(oam_reset), .remote_event(remote_event), .evt(evt)
  );

  lom_peer u_peer (
    .pclk(pclk), .err_in(err_in), .remote_event(remote_event)
  );

  // Event pulses last one cycle, so they are counted on every edge.
  always @(posedge pclk)
  begin
    for (int i = 0; i < 4; i++)
      seen[i] <= seen[i] + int'(evt[i]);
    if (evt.frame === 1'b1)
      t_fe <= $time;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    num_errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask : chk

  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    errv = pslverr;
    if (n >= 16)
      fail("no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e, $sformatf("addr %h", a));
  endtask : rd

  // The wait is bounded so a missing pulse cannot hang the run.
  task automatic wait_evt(input int i, input int n, input int lim);
    int c = 0;
    while (seen[i] < n && c < lim)
    begin
      @(posedge pclk);
      c++;
    end
    chk(32'(seen[i]), 32'(n), "event count");
  endtask : wait_evt

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    #100000;
    num_errors++;
    complete_run;
  end

  // Main sequence; windows shrink so every close is reached quickly.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    oam_reset = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t0 = $time;
    rd(A_CTRL, 32'h0);
    rd(A_FE_WIN, 32'hA);
    rd(A_FE_THR, 32'h1);
    rd(A_FP_WIN, FP_WIN_RST);
    rd(A_FP_THR, FP_THR_RST);
    rd(A_SP_WL, SP_WIN_RST[31:0]);
    rd(A_SP_WH, SP_WIN_RST[63:32]);
    rd(A_SP_RL, SP_THR_RST[31:0]);
    rd(A_ES_WIN, {16'h0, ES_WIN_RST});
    rd(A_ES_THR, {16'h0, ES_THR_RST});
    wr(8'h80, 32'h1);
    chk(32'(errv), 32'h1, "write error");
    rd(8'h80, 32'h0);
    chk(32'(errv), 32'h1, "read error");
    wr(A_FE_WIN, 32'h2BC);
    rd(A_FE_WIN, 32'h258);
    wr(A_FE_WIN, 32'h5);
    rd(A_FE_WIN, 32'hA);
    wr(A_ES_WIN, 32'h0);
    rd(A_ES_WIN, 32'h1);
    wr(A_ES_WIN, {16'h0, ES_WIN_RST});
    wr(A_FE_WIN, 32'hA);
    u_peer.events(3);
    rd(A_SEQ, 32'h3);
    wr(A_FE_THR, 32'h2);
    wr(A_CTRL, 32'h1);
    u_peer.burst(3, 2, 0, 0);
    rd(A_FE_CNT, 32'h2);
    rd(A_SEQ, 32'h0);
    wait_evt(0, 1, 100);
    rd(A_FE_TL, 32'h2);
    rd(A_FE_CNT, 32'h0);
    rd(A_FE_EV, 32'h1);
    apb(1'b0, A_FE_TS, 32'h0);
    samples_checked++;
    if ($isunknown(rdv) || rdv > (t_fe - t0) / 32 + 2
        || rdv + 2 < (t_fe - t0) / 32)
      fail("timestamp");
    wr(A_ES_WIN, 32'hA);
    wait_evt(3, 1, 400);
    rd(A_ES_TOT, 32'h1);
    rd(A_ES_EV, 32'h1);
    @(posedge pclk);
    oam_reset <= 1'b1;
    @(posedge pclk);
    oam_reset <= 1'b0;
    rd(A_FE_TL, 32'h0);
    rd(A_FE_EV, 32'h0);
    rd(A_ES_TOT, 32'h0);
    wr(A_SP_WL, 32'h8);
    wr(A_SP_RL, 32'h2);
    u_peer.burst(0, 0, 8, 3);
    wait_evt(2, 1, 10);
    rd(A_SP_TL, 32'h3);
    rd(A_SP_CL, 32'h0);
    rd(A_SP_EV, 32'h1);
    u_peer.burst(0, 0, 6, 1);
    rd(A_SP_CL, 32'h1);
    u_peer.burst(0, 0, 2, 0);
    rd(A_SP_TL, 32'h4);
    rd(A_SP_EV, 32'h1);
    chk(32'(seen[2]), 32'h1, "symbol pulses");
    wr(A_FP_WIN, 32'h4);
    wr(A_FP_THR, 32'h0);
    u_peer.burst(2, 1, 0, 0);
    rd(A_FP_CNT, 32'h1);
    u_peer.burst(2, 0, 0, 0);
    wait_evt(1, 1, 10);
    rd(A_FP_TL, 32'h1);
    rd(A_FP_EV, 32'h1);
    u_peer.burst(4, 0, 0, 0);
    wait_evt(1, 2, 10);
    rd(A_FP_EV, 32'h2);
    complete_run;
  end
endmodule : lom_monitor_test
